// ---- pcj_defines.svh ----
// constants for the port c/d test-port pin mux
// assumes inclusion by pcj_pkg and the mux modules
`ifndef PCJ_DEFINES_SVH
`define PCJ_DEFINES_SVH

`define PCJ_PIN_COUNT      7
// pin indices within the group
`define PCJ_IDX_C12        0
`define PCJ_IDX_D4         1
`define PCJ_IDX_D5         2
`define PCJ_IDX_D0         3
`define PCJ_IDX_D1         4
`define PCJ_IDX_D2         5
`define PCJ_IDX_D3         6
// function select reset value: 1 = alternate/test, 0 = general purpose
`define PCJ_ALT_RESET      7'h78
`define PCJ_DIR_RESET      7'h00
`define PCJ_OUT_RESET      7'h00
`define PCJ_SYNC_RESET     3'h7

`endif

// ---- pcj_pkg.sv ----
// types for the port c/d test-port pin mux
// assumes pcj_defines.svh is on the include path
package pcj_pkg;
`include "pcj_defines.svh"

	typedef logic [`PCJ_PIN_COUNT-1:0] pcjPinVec_t;

	typedef struct packed {
		logic [2:0] tck;
		logic [2:0] tdi;
		logic [2:0] tms;
		logic       tdi_q;
		logic       tms_q;
		logic       tdoOut;
		logic       tdoDrv;
	} pcj_tap_t;

	typedef struct packed {
		pcjPinVec_t altSel;
		pcjPinVec_t dirOut;
		pcjPinVec_t outVal;
		pcjPinVec_t sync1;
		pcjPinVec_t sync2;
		pcjPinVec_t sync3;
		pcjPinVec_t inStable;
	} pcj_cfg_t;
endpackage

// ---- pcj_test_port.sv ----
// test-port pin sampling: finds test clock edges, samples data and mode select,
// updates test data output on falling edges
// assumes the test clock is slow (160 ns) relative to clock
`include "pcj_defines.svh"
module pcj_test_port
	import pcj_pkg::*;
(
	input  wire logic clock,
	input  wire logic reset_n,
	input  wire logic tckPin,
	input  wire logic tdiPin,
	input  wire logic tmsPin,
	input  wire logic tapShiftState,
	input  wire logic tapSerialOut,
	output logic      tckRise,
	output logic      tdiSample,
	output logic      tmsSample,
	output logic      tdoOut,
	output logic      tdoDrive
);
	pcj_tap_t s_q;
	pcj_tap_t s_d;
	logic     rise;
	logic     fall;

	// edges come from stages two and three only
	assign rise = s_q.tck[1] & ~s_q.tck[2];
	assign fall = ~s_q.tck[1] & s_q.tck[2];

	always_comb begin
		s_d = s_q;
		s_d.tck = {s_q.tck[1:0], tckPin};
		s_d.tdi = {s_q.tdi[1:0], tdiPin};
		s_d.tms = {s_q.tms[1:0], tmsPin};
		if (rise) begin
			s_d.tdi_q = s_q.tdi[1]; // see R07
			s_d.tms_q = s_q.tms[1]; // see R12
		end
		if (fall) begin
			s_d.tdoOut = tapSerialOut; // see R09
			s_d.tdoDrv = tapShiftState; // see R08
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.tck <= `PCJ_SYNC_RESET;
			s_q.tdi <= `PCJ_SYNC_RESET;
			s_q.tms <= `PCJ_SYNC_RESET;
			s_q.tdi_q <= 1'b1;
			s_q.tms_q <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign tckRise   = rise;
	assign tdiSample = s_q.tdi_q;
	assign tmsSample = s_q.tms_q;
	assign tdoOut    = s_q.tdoOut;
	assign tdoDrive  = s_q.tdoDrv;
endmodule

// ---- pcj_pin_mux.sv ----
// pin mux for port c pin twelve, port d pins zero to five and the test port
// Operation
// R01: each pin is independently input or output when general purpose is selected
// R02: port c pin twelve resets to general purpose; alternate is converter b input four
// R03: port d pin four resets to general purpose; alternate is crystal input
// R04: port d pin five resets to general purpose; alternates crystal output, clock input
// R05: general purpose pins are inputs with driver off during reset
// R06: test data input pin resets to test function
// R07: test data input sampled on each rising test clock edge
// R08: test data output driven only in shift-ir or shift-dr
// R09: test data output updates on each falling test clock edge
// R10: test data output floats during reset, test function after reset
// R11: test clock pin resets to test function, probe gates the clock
// R12: mode select resets to test function, sampled on rising test clock
// R13: alternate function choice comes from the system integration unit settings
// R14: function selects are synchronous bits reset to defaults, changed by writes only
// assumes the system integration unit drives the select write port and
// the test-access-port controller sits outside this block
`include "pcj_defines.svh"
module pcj_pin_mux
	import pcj_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       reset_n,
	// system integration unit function-select write
	input  wire logic       altSelWrite,
	input  wire pcjPinVec_t altSelData,
	// port software: direction and output value
	input  wire logic       dirWrite,
	input  wire pcjPinVec_t dirData,
	input  wire logic       outWrite,
	input  wire pcjPinVec_t outData,
	output pcjPinVec_t      altSelState,
	output pcjPinVec_t      dirState,
	output pcjPinVec_t      portInput,
	// pads: in, out, output enable (low = drive)
	input  wire pcjPinVec_t padIn,
	output pcjPinVec_t      padOut,
	output pcjPinVec_t      padOe_n,
	// analog and clock routing enables
	output logic            converterBInputFourEn,
	output logic            crystalInputEn,
	output logic            crystalOutputEn,
	// test-access-port controller side
	input  wire logic       tapShiftState,
	input  wire logic       tapSerialOut,
	output logic            tapClockRise,
	output logic            tapDataIn,
	output logic            tapModeSelect
);
	pcj_cfg_t   c_q;
	pcj_cfg_t   c_d;
	logic       tdoOut;
	logic       tdoDrive;

	////////////////////////////////////////////////////////////////////////////
	// configuration registers
	always_comb begin
		c_d = c_q;
		if (altSelWrite)
			c_d.altSel = altSelData; // see R13 see R14
		if (dirWrite)
			c_d.dirOut = dirData; // see R01
		if (outWrite)
			c_d.outVal = outData;
		// input synchronisers; a change counts once stages two and three agree
		c_d.sync1    = padIn;
		c_d.sync2    = c_q.sync1;
		c_d.sync3    = c_q.sync2;
		c_d.inStable = (c_q.sync2 & c_q.sync3) | (c_q.inStable & (c_q.sync2 | c_q.sync3));
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			c_q.altSel <= `PCJ_ALT_RESET; // see R02 see R03 see R04 see R06 see R11 see R12 see R14
			c_q.dirOut <= `PCJ_DIR_RESET; // see R05
			c_q.outVal <= `PCJ_OUT_RESET;
			c_q.sync1    <= '0;
			c_q.sync2    <= '0;
			c_q.sync3    <= '0;
			c_q.inStable <= '0;
		end else begin
			c_q <= c_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// test port
	pcj_test_port u_test_port (
		.clock         (clock),
		.reset_n       (reset_n),
		.tckPin        (padIn[`PCJ_IDX_D2]),
		.tdiPin        (padIn[`PCJ_IDX_D0]),
		.tmsPin        (padIn[`PCJ_IDX_D3]),
		.tapShiftState (tapShiftState),
		.tapSerialOut  (tapSerialOut),
		.tckRise       (tapClockRise),
		.tdiSample     (tapDataIn),
		.tmsSample     (tapModeSelect),
		.tdoOut        (tdoOut),
		.tdoDrive      (tdoDrive)
	);

	////////////////////////////////////////////////////////////////////////////
	// pad drive; outputs stay registered-only, gated by select
	// reset clears direction bits and the tdo drive flag, so drivers stay off throughout
	always_comb begin
		for (int i = 0; i < `PCJ_PIN_COUNT; i++) begin
			padOut[i]  = c_q.outVal[i];
			padOe_n[i] = ~(c_q.dirOut[i] & ~c_q.altSel[i]); // see R01 see R05
		end
		// tdo: floats unless shifting, floats in reset since shift flag resets low
		padOut[`PCJ_IDX_D1] = c_q.altSel[`PCJ_IDX_D1] ? tdoOut : c_q.outVal[`PCJ_IDX_D1];
		if (c_q.altSel[`PCJ_IDX_D1])
			padOe_n[`PCJ_IDX_D1] = ~tdoDrive; // see R08 see R10
	end

	assign portInput   = c_q.inStable & ~c_q.altSel;
	assign altSelState = c_q.altSel;
	assign dirState    = c_q.dirOut;

	assign converterBInputFourEn = c_q.altSel[`PCJ_IDX_C12]; // see R02
	assign crystalInputEn        = c_q.altSel[`PCJ_IDX_D4]; // see R03
	assign crystalOutputEn       = c_q.altSel[`PCJ_IDX_D5]; // see R04
endmodule

// ---- pcj_pin_mux_props.sv ----
// checker for the port c/d test-port pin mux
// assumes it is bound onto pcj_pin_mux
`include "pcj_defines.svh"
module pcj_pin_mux_props
	import pcj_pkg::*;
(
	input wire logic       clock,
	input wire logic       reset_n,
	input wire logic       altSelWrite,
	input wire pcjPinVec_t altSelData,
	input wire logic       dirWrite,
	input wire pcjPinVec_t dirData,
	input wire pcjPinVec_t altSelState,
	input wire pcjPinVec_t dirState,
	input wire pcjPinVec_t padOe_n,
	input wire logic       converterBInputFourEn,
	input wire logic       tapClockRise
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	a_reset_sel: assert property ($rose(reset_n) |-> altSelState == `PCJ_ALT_RESET)
		else $error("bad select reset");
	a_reset_oe: assert property ($rose(reset_n) |-> dirState == 7'h00 && padOe_n == 7'h7F)
		else $error("pins driven at reset");
	a_sel_write: assert property (altSelWrite |=> altSelState == $past(altSelData))
		else $error("select write lost");
	a_sel_hold: assert property (!altSelWrite |=> $stable(altSelState))
		else $error("select moved");
	a_dir_write: assert property (dirWrite |=> dirState == $past(dirData))
		else $error("dir write lost");
	a_gpio_oe: assert property ((padOe_n & 7'h6F) == (~(dirState & ~altSelState) & 7'h6F))
		else $error("bad enable");
	a_conv_en: assert property (altSelWrite |=> converterBInputFourEn == $past(altSelData[0]))
		else $error("bad routing");
	a_rise_pulse: assert property (tapClockRise |=> !tapClockRise)
		else $error("long pulse");
	cover property (altSelWrite);
	cover property (dirWrite);
	cover property (tapClockRise);
endmodule
bind pcj_pin_mux pcj_pin_mux_props props_u (.clock, .reset_n, .altSelWrite, .altSelData, .dirWrite,
	.dirData, .altSelState, .dirState, .padOe_n, .converterBInputFourEn, .tapClockRise);

// ---- pcj_probe.sv ----
// debug probe model: test clock, data and mode select
// assumes the bench wires the pads; clock idles high like the pulled-up pin
module pcj_probe (
	output logic       tck,
	output logic       tdi,
	output logic       tms,
	input  wire logic  tdo,
	output logic [7:0] got
);
	timeunit 1ns;
	timeprecision 100ps;
	initial {tck, tdi, tms} = 3'h7;
	// data moves at the fall so it is steady over the rise
	task automatic shift(input logic [7:0] d, input logic [7:0] m);
		for (int i = 0; i < 8; i++) begin
			tck = 1'h0;
			{tdi, tms} = {d[i], m[i]};
			#80 tck = 1'h1;
			got = {tdo, got[7:1]};
			#80;
		end
		{tdi, tms} = 2'h3;
	endtask
endmodule

// ---- pcj_pin_mux_test.sv ----
// self-checking bench for the port c/d test-port pin mux
// assumes the probe model and the bound checker
`include "pcj_defines.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; $display("[FAIL] %0t mismatch", $time); end end
module pcj_pin_mux_test
	import pcj_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clock = 1'h0, reset_n = 1'h0, altSelWrite = 1'h0, dirWrite = 1'h0, outWrite = 1'h0;
	logic       tapShiftState = 1'h0;
	pcjPinVec_t altSelData = 7'h00, dirData = 7'h00, outData = 7'h00, ext = 7'h7D;
	pcjPinVec_t altSelState, dirState, portInput, padOut, padOe_n, padIn;
	logic       conv, xin, xout, rise, tdiQ, tmsQ, tck, tdi, tms;
	logic [7:0] got;
	int         n_mismatch = 0, n_compared = 0, ticks = 0, nRise = 0;
	// released tdo floats up to its pull-up
	assign padIn = (padOut & ~padOe_n) | ({tms, tck, 1'h1, tdi, ext[2:0]} & padOe_n);
	always #4 clock = ~clock;
	always @(posedge clock) begin
		nRise += (rise === 1'h1);
		if (++ticks == 1000) begin
			n_mismatch++;
			results();
		end
	end
	pcj_pin_mux dut_u (.clock, .reset_n, .altSelWrite, .altSelData, .dirWrite, .dirData, .outWrite, .outData,
		.altSelState, .dirState, .portInput, .padIn, .padOut, .padOe_n, .converterBInputFourEn(conv),
		.crystalInputEn(xin), .crystalOutputEn(xout), .tapShiftState, .tapSerialOut(tdiQ),
		.tapClockRise(rise), .tapDataIn(tdiQ), .tapModeSelect(tmsQ));
	pcj_probe probe_u (.tck, .tdi, .tms, .tdo(padIn[4]), .got);
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr(input pcjPinVec_t a, input pcjPinVec_t d, input pcjPinVec_t o);
		{altSelData, dirData, outData} = {a, d, o};
		{altSelWrite, dirWrite, outWrite} = 3'h7;
		cyc(1);
		{altSelWrite, dirWrite, outWrite} = 3'h0;
		cyc(1);
	endtask
	task automatic t_reset;
		`CHK(altSelState, `PCJ_ALT_RESET)
		`CHK(padOe_n, 7'h7F)
		`CHK({conv, xin, xout}, 3'h0)
	endtask
	task automatic t_gpio;
		wr(7'h00, 7'h55, 7'h2A);
		`CHK(dirState, 7'h55)
		`CHK(padOe_n, 7'h2A)
		`CHK(padOut, 7'h2A)
		cyc(6);
		`CHK(portInput, 7'h28)
	endtask
	task automatic t_midreset;
		reset_n = 1'h0;
		cyc(2);
		t_reset();
		reset_n = 1'h1;
		cyc(1);
	endtask
	task automatic t_alt;
		wr(7'h07, 7'h7F, 7'h00);
		cyc(1);
		`CHK({conv, xin, xout}, 3'h7)
		`CHK(padOe_n, 7'h07)
		`CHK(altSelState, 7'h07)
		wr(`PCJ_ALT_RESET, 7'h00, 7'h00);
		// driven test pads toggled tck; let that edge pass before counting
		cyc(6);
	endtask
	task automatic t_jtag;
		tapShiftState = 1'h1;
		nRise = 0;
		probe_u.shift(8'hB4, 8'h01);
		cyc(6);
		`CHK(got, 8'h69)
		`CHK(tmsQ, 1'h0)
		`CHK(nRise, 8)
		tapShiftState = 1'h0;
		probe_u.shift(8'h00, 8'h00);
		cyc(6);
		`CHK(got, 8'hFF)
		`CHK(padOe_n[4], 1'h1)
	endtask
	task automatic results;
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		cyc(2);
		t_reset();
		reset_n = 1'h1;
		cyc(1);
		t_gpio();
		t_midreset();
		t_alt();
		t_jtag();
		results();
	end
endmodule
